/* File: core/sfl_core.sv */
// Scalar flow control, program end, upstream messaging and scalar loads for one wave.
// Assumes wave state and instructions arrive from logic on clk; registers are reached over AHB-Lite.
//
// Contract
// - Condition-code branch taken on match: pc plus signed immediate times four plus four.
// - Condition-mask branch taken on zero or nonzero variant, else pc plus four.
// - Lane-mask branch taken on zero or nonzero variant, else pc plus four.
// - Branch when system debug flag set, else pc plus four.
// - Branch when user debug flag set, else pc plus four.
// - Branch when either debug flag set, else pc plus four.
// - Branch only when both debug flags set, else pc plus four.
// - Every program end waits until all outstanding counters are zero.
// - Saved program end signals saved upstream and terminates in the same cycle.
// - Ordered program end signals ordered section done and terminates.
// - Group wake from an in-group wave pings all waves of that group.
// - Ping affects only sleeping waves; others finish their sleep.
// - Group wake outside a group is a no-operation.
// - Set-priority loads user priority from immediate bits one to zero.
// - Wave priority is saturated system plus user priority above the age.
// - Send-message delivers upstream message typed by immediate bits seven to zero.
// - Send-and-halt delivers the same message and halts the wave.
// - Perf instructions step the selected counter up or down by one.
// - Barrier holds until the whole surviving group is created and arrived.
// - Barrier issues without waiting on counters.
// - Register offset unsigned with low two bits dropped; immediate offset signed 21 bits.
// - Loads return 1 to 16 dwords, dword k from address plus 4k.
`timescale 1ns/1ps

module sfl_core #(
  parameter int GROUP_WAVES = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic instr_valid,
  input wire sfl_pkg::sfl_instr_t instr,
  output logic instr_ready,
  input wire sfl_pkg::sfl_wave_t wave,
  output logic [sfl_pkg::PC_W-1:0] pc_out,
  output sfl_pkg::sfl_up_t up,
  input wire logic group_all_created,
  input wire logic [GROUP_WAVES-1:0] group_live_pending,
  output logic cache_req_valid,
  input wire logic cache_req_ready,
  output logic [sfl_pkg::PC_W-1:0] cache_req_addr,
  input wire logic cache_rsp_valid,
  input wire logic [31:0] cache_rsp_data,
  output logic load_done,
  output logic [sfl_pkg::DEST_W-1:0] load_data,
  output logic [5:0] wave_priority
);
  import sfl_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    sfl_fsm_t fsm;
    sfl_end_t end_kind;
    logic [PC_W-1:0] pc;
    logic enable;
    logic [1:0] system_priority;
    logic [1:0] user_priority;
    logic [3:0] wave_age_a;
    logic [5:0] prio;
    logic instr_ready;
    sfl_up_t up;
    logic [PERF_NUM-1:0][PERF_W-1:0] perf;
    logic req_valid;
    logic [PC_W-1:0] ld_addr;
    logic [4:0] ld_left;
    logic [4:0] ld_idx;
    logic [4:0] ld_total;
    logic [DEST_W-1:0] ld_data;
    logic load_done;
    logic dp_write;
    logic [ADDR_W-1:0] dp_addr;
    logic [31:0] hrdata;
    logic hreadyout;
  } sfl_state_t;

  localparam sfl_state_t STATE_RST = '{fsm: st_idle, end_kind: end_plain, enable: CTRL_ENABLE_RST,
                                       instr_ready: CTRL_ENABLE_RST, hreadyout: 1'b1, pc: PC_RST, default: '0};

  sfl_state_t s;
  sfl_state_t next_s;
  logic accept;
  logic counters_idle;
  logic [PC_W-1:0] imm_scaled;
  logic [PC_W-1:0] fall_pc;
  logic [PC_W-1:0] taken_pc;

  assign accept = instr_valid && s.instr_ready;
  assign counters_idle = (wave.load_cnt == '0) && (wave.share_cnt == '0) && (wave.export_cnt == '0) &&
                         (wave.store_cnt == '0);
  assign imm_scaled = {{(PC_W - IMM_W - 2){instr.instruction_immediate[IMM_W-1]}}, instr.instruction_immediate, 2'b00};
  assign fall_pc = s.pc + PC_STEP;
  assign taken_pc = s.pc + imm_scaled + PC_STEP;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic take;
    logic [PC_W-1:0] offset;
    logic [2:0] size_log;
    logic [2:0] prio_sum;
    logic [4:0] idx_inc;
    next_s = s;
    take = 1'b0;
    offset = '0;
    size_log = '0;
    prio_sum = '0;
    idx_inc = '0;
    next_s.up.msg_valid = 1'b0;
    next_s.up.terminate = 1'b0;
    next_s.up.saved = 1'b0;
    next_s.up.ordered_done = 1'b0;
    next_s.up.wake_valid = 1'b0;
    next_s.up.barrier_arrive = 1'b0;
    next_s.up.icache_flush = 1'b0;
    next_s.load_done = 1'b0;
    case (instr.op)
      op_branch_if_condition_zero: take = !wave.scalar_condition_code;
      op_branch_if_condition_one: take = wave.scalar_condition_code;
      op_branch_if_mask_zero: take = (wave.condition_mask == '0);
      op_branch_if_mask_set: take = (wave.condition_mask != '0);
      op_branch_if_lanes_idle: take = (wave.lane_execute_mask == '0);
      op_branch_if_lanes_active: take = (wave.lane_execute_mask != '0);
      op_branch_if_system_debug: take = wave.system_debug_condition;
      op_branch_if_user_debug: take = wave.user_debug_condition;
      op_branch_if_any_debug: take = wave.system_debug_condition || wave.user_debug_condition;
      op_branch_if_both_debug: take = wave.system_debug_condition && wave.user_debug_condition;
      default: take = 1'b0;
    endcase
    if (accept) begin
      next_s.pc = take ? taken_pc : fall_pc;
      case (instr.op)
        op_end_program: begin
          next_s.fsm = st_drain;
          next_s.end_kind = end_plain;
        end
        op_end_program_saved: begin
          next_s.fsm = st_drain;
          next_s.end_kind = end_saved;
        end
        op_end_program_ordered_done: begin
          next_s.fsm = st_drain;
          next_s.end_kind = end_ordered;
        end
        op_wake_group: begin
          // Sleeping waves outside decide whether the ping matters to them.
          next_s.up.wake_valid = wave.in_group_flag;
          next_s.up.wake_group = wave.group_id;
        end
        op_set_user_priority: next_s.user_priority = instr.instruction_immediate[IMM_PRIO_MSB:0];
        op_send_upstream_message, op_send_message_and_halt: begin
          next_s.up.msg_valid = 1'b1;
          next_s.up.msg_type = instr.instruction_immediate[IMM_MSG_MSB:0];
          if (instr.op == op_send_message_and_halt) begin
            next_s.fsm = st_halted;
          end
        end
        op_perf_counter_step: begin
          next_s.perf[instr.instruction_immediate[IMM_PERF_MSB:0]] =
            s.perf[instr.instruction_immediate[IMM_PERF_MSB:0]] + PERF_W'(1);
        end
        op_perf_counter_unstep: begin
          next_s.perf[instr.instruction_immediate[IMM_PERF_MSB:0]] =
            s.perf[instr.instruction_immediate[IMM_PERF_MSB:0]] - PERF_W'(1);
        end
        op_instruction_cache_flush: next_s.up.icache_flush = 1'b1;
        op_barrier: begin
          // Arrival is announced at once, with no counter drain.
          next_s.up.barrier_arrive = 1'b1;
          next_s.fsm = st_barrier;
        end
        op_scalar_load_dwords, op_scalar_buffer_load_dwords: begin
          if (instr.offset_from_reg) begin
            offset = {16'h0000, instr.reg_offset[31:2], 2'b00};
          end else begin
            offset = {{(PC_W - 21){instr.imm_offset[20]}}, instr.imm_offset};
          end
          size_log = (instr.size_log > SIZE_LOG_MAX) ? SIZE_LOG_MAX : instr.size_log;
          next_s.ld_addr = instr.base_addr + offset;
          next_s.ld_total = 5'h01 << size_log;
          next_s.ld_left = 5'h01 << size_log;
          next_s.ld_idx = '0;
          next_s.ld_data = '0;
          next_s.req_valid = 1'b1;
          next_s.fsm = st_load;
        end
        default: begin
        end
      endcase
    end
    case (s.fsm)
      st_drain: begin
        if (counters_idle) begin
          next_s.up.terminate = 1'b1;
          next_s.up.saved = (s.end_kind == end_saved);
          next_s.up.ordered_done = (s.end_kind == end_ordered);
          next_s.fsm = st_ended;
        end
      end
      st_barrier: begin
        // Terminated waves are not in the pending vector, so they are not waited on.
        if (group_all_created && (group_live_pending == '0)) begin
          next_s.fsm = st_idle;
        end
      end
      st_load: begin
        if (s.req_valid && cache_req_ready) begin
          next_s.ld_addr = s.ld_addr + DWORD_STEP;
          next_s.ld_left = s.ld_left - 5'h01;
          next_s.req_valid = (s.ld_left != 5'h01);
        end
        if (cache_rsp_valid) begin
          idx_inc = s.ld_idx + 5'h01;
          next_s.ld_data[32 * s.ld_idx +: 32] = cache_rsp_data;
          next_s.ld_idx = idx_inc;
          if (idx_inc == s.ld_total) begin
            next_s.load_done = 1'b1;
            next_s.fsm = st_idle;
          end
        end
      end
      default: begin
      end
    endcase
    // Bus data phase: a write lands here and overrides the instruction path.
    if (s.dp_write) begin
      case (s.dp_addr)
        REG_CTRL: begin
          next_s.enable = hwdata[CTRL_ENABLE_BIT];
          next_s.system_priority = hwdata[CTRL_SYSTEM_PRIORITY_LSB +: 2];
          if (hwdata[CTRL_RESUME_BIT] && ((s.fsm == st_halted) || (s.fsm == st_ended))) begin
            next_s.fsm = st_idle;
          end
        end
        REG_PC_LO: next_s.pc[31:0] = hwdata;
        REG_PC_HI: next_s.pc[PC_W-1:32] = hwdata[PC_W-33:0];
        REG_AGE: next_s.wave_age_a = hwdata[3:0];
        default: begin
        end
      endcase
    end
    // Bus address phase: read data is latched for the following data phase.
    next_s.dp_write = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_s.dp_write = hwrite;
      next_s.dp_addr = haddr[ADDR_W-1:0];
      next_s.hrdata = '0;
      if (!hwrite) begin
        case (haddr[ADDR_W-1:0])
          REG_CTRL: begin
            next_s.hrdata[CTRL_ENABLE_BIT] = s.enable;
            next_s.hrdata[CTRL_SYSTEM_PRIORITY_LSB +: 2] = s.system_priority;
          end
          REG_STATUS: begin
            next_s.hrdata[ST_FSM_LSB +: 3] = s.fsm;
            next_s.hrdata[ST_HALT_BIT] = s.up.halted;
            next_s.hrdata[ST_ENABLE_BIT] = s.enable;
            next_s.hrdata[ST_UPRIO_LSB +: 2] = s.user_priority;
            next_s.hrdata[ST_SPRIO_LSB +: 2] = s.system_priority;
            next_s.hrdata[ST_PRIO_LSB +: 6] = s.prio;
          end
          REG_PC_LO: next_s.hrdata = s.pc[31:0];
          REG_PC_HI: next_s.hrdata[PC_W-33:0] = s.pc[PC_W-1:32];
          REG_AGE: next_s.hrdata[3:0] = s.wave_age_a;
          default: begin
            if (haddr[ADDR_W-1:ADDR_W-2] == REG_PERF_PAGE) begin
              next_s.hrdata[PERF_W-1:0] = s.perf[haddr[5:2]];
            end
          end
        endcase
      end
    end
    prio_sum = {1'b0, next_s.system_priority} + {1'b0, next_s.user_priority};
    next_s.prio = {((prio_sum > PRIO_SAT) ? PRIO_SAT[1:0] : prio_sum[1:0]), next_s.wave_age_a};
    next_s.up.halted = (next_s.fsm == st_halted);
    next_s.instr_ready = (next_s.fsm == st_idle) && next_s.enable;
    next_s.hreadyout = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s <= STATE_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = 1'b0;
  assign instr_ready = s.instr_ready;
  assign pc_out = s.pc;
  assign up = s.up;
  assign cache_req_valid = s.req_valid;
  assign cache_req_addr = s.ld_addr;
  assign load_done = s.load_done;
  assign load_data = s.ld_data;
  assign wave_priority = s.prio;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst || !ce);

  sequence acc_op(sfl_op_t o);
    accept && (instr.op == o) && !s.dp_write;
  endsequence

  cond_branch_a: assert property (acc_op(op_branch_if_condition_zero) ##0 !wave.scalar_condition_code |=>
    pc_out == $past(s.pc + imm_scaled + 48'h0000_0000_0004)) else $error("condition branch target wrong");
  mask_fall_a: assert property (acc_op(op_branch_if_mask_zero) ##0 (wave.condition_mask != '0) |=>
    pc_out == $past(s.pc) + 48'h0000_0000_0004) else $error("mask branch did not fall through");
  lanes_taken_a: assert property (acc_op(op_branch_if_lanes_active) ##0 (wave.lane_execute_mask != '0) |=>
    pc_out == $past(taken_pc)) else $error("lane branch not taken");
  debug_both_a: assert property (acc_op(op_branch_if_both_debug) ##0 !wave.user_debug_condition |=>
    pc_out == $past(fall_pc)) else $error("both-debug branch taken wrongly");
  drain_wait_a: assert property ($rose(up.terminate) |-> $past(counters_idle))
    else $error("ended with counters busy");
  saved_end_a: assert property (up.saved |-> up.terminate && !up.ordered_done)
    else $error("saved without end");
  ordered_end_a: assert property (s.fsm == st_drain && s.end_kind == end_ordered && counters_idle |=>
    up.ordered_done && up.terminate) else $error("ordered end missing");
  wake_nop_a: assert property (acc_op(op_wake_group) ##0 !wave.in_group_flag |=> !up.wake_valid)
    else $error("wake outside group");
  wake_ping_a: assert property (acc_op(op_wake_group) ##0 wave.in_group_flag |=>
    up.wake_valid && up.wake_group == $past(wave.group_id)) else $error("group wake missing");
  prio_sat_a: assert property (acc_op(op_set_user_priority) ##0
    (instr.instruction_immediate[1:0] == 2'h3) |=> wave_priority[5:4] == 2'h3) else $error("priority not saturated");
  msg_halt_a: assert property (acc_op(op_send_message_and_halt) |=> up.msg_valid && up.halted &&
    up.msg_type == $past(instr.instruction_immediate[7:0]) ##1 !instr_ready) else $error("send and halt wrong");
  barrier_go_a: assert property (acc_op(op_barrier) |=> up.barrier_arrive && !instr_ready)
    else $error("barrier not held");
  load_step_a: assert property (cache_req_valid && cache_req_ready && s.fsm == st_load |=>
    cache_req_addr == $past(cache_req_addr) + 48'h0000_0000_0004) else $error("dword address step wrong");

endmodule : sfl_core

/* File: core/sfl_pkg.sv */
// Shared types and constants for the scalar flow control and load unit.
// Assumes one clock domain and AHB-Lite register access from a single master.
package sfl_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int PC_W = 48;
  localparam int IMM_W = 16;
  localparam int MASK_W = 64;
  localparam int GROUP_W = 8;
  localparam int DEST_W = 512;
  localparam int PERF_NUM = 16;
  localparam int PERF_W = 16;
  localparam int ADDR_W = 8;
  localparam int IMM_MSG_MSB = 7;
  localparam int IMM_PRIO_MSB = 1;
  localparam int IMM_PERF_MSB = 3;
  localparam logic [PC_W-1:0] PC_STEP = 48'h0000_0000_0004;
  localparam logic [PC_W-1:0] PC_RST = 48'h0000_0000_0000;
  localparam logic [PC_W-1:0] DWORD_STEP = 48'h0000_0000_0004;
  localparam logic [2:0] SIZE_LOG_MAX = 3'h4;
  localparam logic [2:0] PRIO_SAT = 3'h3;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PC_LO = 8'h08;
  localparam logic [ADDR_W-1:0] REG_PC_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_AGE = 8'h10;
  localparam logic [1:0] REG_PERF_PAGE = 2'h1;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_RESUME_BIT = 1;
  localparam int CTRL_SYSTEM_PRIORITY_LSB = 4;
  localparam int ST_FSM_LSB = 0;
  localparam int ST_HALT_BIT = 3;
  localparam int ST_ENABLE_BIT = 4;
  localparam int ST_UPRIO_LSB = 8;
  localparam int ST_SPRIO_LSB = 10;
  localparam int ST_PRIO_LSB = 16;
  localparam logic CTRL_ENABLE_RST = 1'b1;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [4:0] {
    op_branch_if_condition_zero = 5'h00, op_branch_if_condition_one = 5'h01,
    op_branch_if_mask_zero = 5'h02, op_branch_if_mask_set = 5'h03,
    op_branch_if_lanes_idle = 5'h04, op_branch_if_lanes_active = 5'h05,
    op_branch_if_system_debug = 5'h06, op_branch_if_user_debug = 5'h07,
    op_branch_if_any_debug = 5'h08, op_branch_if_both_debug = 5'h09,
    op_end_program = 5'h0a, op_end_program_saved = 5'h0b, op_end_program_ordered_done = 5'h0c,
    op_wake_group = 5'h0d, op_set_user_priority = 5'h0e, op_send_upstream_message = 5'h0f,
    op_send_message_and_halt = 5'h10, op_perf_counter_step = 5'h11, op_perf_counter_unstep = 5'h12,
    op_instruction_cache_flush = 5'h13, op_barrier = 5'h14,
    op_scalar_load_dwords = 5'h15, op_scalar_buffer_load_dwords = 5'h16, op_nop = 5'h1f
  } sfl_op_t;

  typedef enum logic [2:0] {
    st_idle = 3'h0, st_drain = 3'h1, st_barrier = 3'h2, st_load = 3'h3, st_halted = 3'h4, st_ended = 3'h5
  } sfl_fsm_t;

  typedef enum logic [1:0] {end_plain = 2'h0, end_saved = 2'h1, end_ordered = 2'h2} sfl_end_t;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    sfl_op_t op;
    logic [IMM_W-1:0] instruction_immediate;
    logic offset_from_reg;
    logic [31:0] reg_offset;
    logic [20:0] imm_offset;
    logic [PC_W-1:0] base_addr;
    logic [2:0] size_log;
  } sfl_instr_t;

  typedef struct packed {
    logic scalar_condition_code;
    logic [MASK_W-1:0] condition_mask;
    logic [MASK_W-1:0] lane_execute_mask;
    logic system_debug_condition;
    logic user_debug_condition;
    logic in_group_flag;
    logic [GROUP_W-1:0] group_id;
    logic [5:0] load_cnt;
    logic [5:0] share_cnt;
    logic [2:0] export_cnt;
    logic [5:0] store_cnt;
  } sfl_wave_t;

  typedef struct packed {
    logic msg_valid;
    logic [IMM_MSG_MSB:0] msg_type;
    logic halted;
    logic terminate;
    logic saved;
    logic ordered_done;
    logic wake_valid;
    logic [GROUP_W-1:0] wake_group;
    logic barrier_arrive;
    logic icache_flush;
  } sfl_up_t;

endpackage : sfl_pkg

/* File: dv/sfl_cache_model.sv */
// Behavioural scalar data cache that answers load requests in order.
// Assumes the core's request handshake on clk and a synchronous active-high reset.
`timescale 1ns/1ps

module sfl_cache_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic cache_req_valid,
  input wire logic [47:0] cache_req_addr,
  output logic cache_req_ready,
  output logic cache_rsp_valid,
  output logic [31:0] cache_rsp_data
);
  // ****************************************
  // Request acceptance and in-order replies
  // ****************************************
  logic [31:0] pend_q[$];
  logic tick;
  always @(posedge clk) begin
    if (srst) begin
      pend_q.delete();
      tick <= 1'b0;
      cache_req_ready <= 1'b1;
      cache_rsp_valid <= 1'b0;
      cache_rsp_data <= 32'h0000_0000;
    end else begin
      tick <= ~tick;
      cache_req_ready <= !slow || tick;
      if (cache_req_valid && cache_req_ready) begin
        pend_q.push_back(cache_req_addr[31:0] ^ 32'h5a5a_0000);
      end
      if (pend_q.size() != 0 && (!slow || tick)) begin
        cache_rsp_valid <= 1'b1;
        cache_rsp_data <= pend_q.pop_front();
      end else begin
        cache_rsp_valid <= 1'b0;
        cache_rsp_data <= ~cache_rsp_data;
      end
    end
  end
endmodule : sfl_cache_model

/* File: dv/tb.sv */
// Self-checking bench for the scalar flow control and load unit.
// Assumes sfl_pkg, sfl_core and sfl_cache_model are compiled first.
`timescale 1ns/1ps

module tb;
  import sfl_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk = 0, srst = 1, ce = 1, hsel = 0, hwrite = 0, instr_valid = 0, group_all_created = 1, slow = 0, z;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, cache_rsp_data;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, instr_ready, cache_req_valid, cache_req_ready, cache_rsp_valid, load_done, ir_s, hr_s;
  logic [PC_W-1:0] pc_out, cache_req_addr, epc, a0;
  logic [DEST_W-1:0] load_data;
  logic [5:0] wave_priority;
  logic [15:0] group_live_pending = 0, imm;
  sfl_instr_t instr = '0;
  sfl_wave_t wave = '0;
  sfl_up_t up;
  int n_errors = 0, cmp_count = 0;
  sfl_core i_dut (.clk, .srst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .instr_valid, .instr, .instr_ready, .wave, .pc_out, .up, .group_all_created,
    .group_live_pending, .cache_req_valid, .cache_req_ready, .cache_req_addr, .cache_rsp_valid, .cache_rsp_data,
    .load_done, .load_data, .wave_priority);
  sfl_cache_model i_cache (.clk, .srst, .slow, .cache_req_valid, .cache_req_addr, .cache_req_ready,
    .cache_rsp_valid, .cache_rsp_data);
  initial begin
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    ir_s = instr_ready;
    hr_s = hreadyout;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error: %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hr_s !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hr_s !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic issue(sfl_op_t op, logic [15:0] im);
    instr.op <= op;
    instr.instruction_immediate <= im;
    instr_valid <= 1'b1;
    do @(posedge clk); while (ir_s !== 1'b1);
    instr_valid <= 1'b0;
    epc = epc + PC_STEP;
  endtask : issue
  task automatic await(int s);
    int n = 0;
    do begin
      step;
      n++;
    end while (!(s == 0 ? load_done === 1'b1 : s == 1 ? up.terminate === 1'b1 : instr_ready === 1'b1) && n < 300);
    chk("wait", 1, n < 300);
  endtask : await
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    #100000;
    n_errors++;
    $display("Error: watchdog expected end seen timeout");
    print_verdict;
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    epc = 48'h0000_0000_0100;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    ahb(1'b0, 32'h0000_0020, '0);
    chk("unmapped", 0, rd);
    chk("okay response", 0, hresp);
    ahb(1'b1, 32'h0000_0008, 32'h0000_0100);
    step;
    for (int i = 0; i < 10; i++) begin
      for (int t = 0; t < 2; t++) begin
        z = (i == 0 || i == 2 || i == 4) ? !t[0] : t[0];
        wave.scalar_condition_code <= z;
        wave.condition_mask <= {z, 63'h0};
        wave.lane_execute_mask <= {63'h0, z};
        wave.system_debug_condition <= (i == 7) ? !t[0] : (i == 9) ? 1'b1 : t[0];
        wave.user_debug_condition <= (i == 6) ? !t[0] : (i == 8) ? 1'b0 : t[0];
        imm = t ? 16'hfffe : 16'h0003;
        issue(sfl_op_t'(i), imm);
        if (t == 1) epc = epc + {{30{imm[15]}}, imm, 2'b00};
        step;
        chk("branch pc", epc, pc_out);
      end
    end
    $display("Test branches done");
    ahb(1'b1, 32'h0000_0010, 32'h0000_0005);
    ahb(1'b1, '0, 32'h0000_0021);
    for (int u = 0; u < 4; u++) begin
      issue(op_set_user_priority, 16'hfffc | 16'(u));
      step;
      step;
      chk("priority", {(u > 0) ? 2'h3 : 2'h2, 4'h5}, wave_priority);
    end
    issue(op_send_upstream_message, 16'hff3c);
    #1;
    chk("message", {1'b1, 8'h3c}, {up.msg_valid, up.msg_type});
    issue(op_instruction_cache_flush, '0);
    #1;
    chk("cache flush", 1, up.icache_flush);
    for (int g = 0; g < 2; g++) begin
      wave.in_group_flag <= g[0];
      wave.group_id <= 8'h5a;
      issue(op_wake_group, '0);
      #1;
      chk("wake", g, up.wake_valid);
      if (g == 1) chk("wake group", 8'h5a, up.wake_group);
    end
    issue(op_perf_counter_step, 16'hfff3);
    step;
    issue(op_perf_counter_step, 16'h0003);
    step;
    issue(op_perf_counter_unstep, 16'h0005);
    step;
    ahb(1'b0, 32'h0000_004c, '0);
    chk("perf up", 2, rd);
    ahb(1'b0, 32'h0000_0054, '0);
    chk("perf down", 64'h0000_ffff, rd);
    $display("Test control ops done");
    for (int j = 0; j < 2; j++) begin
      slow <= !j[0];
      instr.base_addr <= j ? 48'h0000_0000_2000 : 48'h0000_0000_1000;
      instr.offset_from_reg <= j[0];
      instr.reg_offset <= 32'h0000_0013;
      instr.imm_offset <= 21'h1f_fff0;
      instr.size_log <= j ? 3'h4 : 3'h1;
      a0 = j ? 48'h0000_0000_2010 : 48'h0000_0000_0ff0;
      issue(j ? op_scalar_buffer_load_dwords : op_scalar_load_dwords, '0);
      await(0);
      for (int d = 0; d < (j ? 16 : 3); d++) begin
        rd = (d < (j ? 16 : 2)) ? (a0[31:0] + 32'(4 * d)) ^ 32'h5a5a_0000 : '0;
        chk("load dword", rd, load_data[32 * d +: 32]);
      end
    end
    $display("Test loads done");
    issue(op_send_message_and_halt, 16'h0077);
    #1;
    chk("halt", {1'b1, 8'h77, 1'b1}, {up.msg_valid, up.msg_type, up.halted});
    ahb(1'b1, '0, 32'h0000_0023);
    wave.load_cnt <= 6'h05;
    group_all_created <= 1'b0;
    group_live_pending <= 16'h0003;
    issue(op_barrier, '0);
    #1;
    chk("arrive", 1, up.barrier_arrive);
    repeat (3) step;
    group_all_created <= 1'b1;
    group_live_pending <= 16'h0001;
    repeat (2) step;
    chk("barrier hold", 0, instr_ready);
    group_live_pending <= '0;
    await(2);
    chk("pc", epc, pc_out);
    $display("Test halt and barrier done");
    for (int v = 0; v < 3; v++) begin
      wave.load_cnt <= (v == 0) ? 6'h01 : 6'h00;
      wave.store_cnt <= (v == 1) ? 6'h01 : 6'h00;
      wave.export_cnt <= (v == 2) ? 3'h1 : 3'h0;
      issue(sfl_op_t'(5'h0a + 5'(v)), '0);
      for (int c = 0; c < 4; c++) begin
        step;
        chk("early end", 0, up.terminate);
      end
      wave <= '0;
      await(1);
      chk("end kind", {v == 1, v == 2}, {up.saved, up.ordered_done});
      ahb(1'b1, '0, 32'h0000_0023);
    end
    $display("Test program end done");
    print_verdict;
  end
endmodule : tb
